//--- scfs_mem_model.sv
/*
 * far side model: the recirculating sector counter line, the command lines
 * and the operand lines. assumes the design registers its write bit once.
 */
`timescale 1ns/1ps
module scfs_mem_model
    import scfs_pkg::*;
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // command word placed on the selected line
    input wire logic [3:0] sel,
    input wire logic [23:0] word,
    // memory lines
    input wire logic write_bit,
    output logic read_bit,
    output logic [15:0] cmd,
    output logic [31:0] opl
);
    logic [22:0] dly_reg;
    logic [4:0] pulse_reg;
    logic tog_reg;
    // 23 stages plus the design's output register close a 24 pulse loop
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            dly_reg <= '0;
            pulse_reg <= BT_FIRST;
            tog_reg <= 1'b0;
        end else begin
            dly_reg <= {dly_reg[21:0], write_bit};
            pulse_reg <= (pulse_reg == BT_LAST) ? BT_FIRST : pulse_reg + 5'h01;
            tog_reg <= ~tog_reg;
        end
    end
    assign read_bit = dly_reg[22];
    // unselected lines carry the inverse so a wrong pick shows
    assign cmd = {16{word[pulse_reg - 5'h01]}} ^ ~(16'h0001 << sel);
    assign opl = {16{tog_reg, ~tog_reg}};
endmodule

//--- scfs_pkg.sv
/*
 * constants, register map and carrier types of the serial command fetch
 * sequencer. assumes one 200 MHz clock where each cycle is one pulse time.
 */
// How it works
// - recirculate counter bits unchanged while carry clear
// - set carry at pulse seven
// - complement read bits while carry set
// - clear carry after first zero bit
// - set carry again at pulse fifteen
// - increment operand sector field the same way
// - always clear carry at pulse twenty three
// - highest sector wraps to zero, carry dropped
// - counter logic runs in all four phases
// - command word from sixteen way line mux
// - phase two pulse two loads index tag
// - line number from word or index field
// - line bits shift downward only under gate
// - phase two shifts opcode under opcode gate
// - phase two copies next sector into register
// - phase two shifts operand sector into register
// - word end: match to phase four, else three
// - phase four lasts one pulse, then one
// - phase one waits match, then phase two
// - standing fetch parity error skips the command
// - operand parity error loops phases one, two
// - phase three waits operand sector, then four
// - decode line into group and member select
package scfs_pkg;
    localparam int PULSES = 24;
    localparam logic [4:0] BT_FIRST = 5'h01;
    localparam logic [4:0] BT_LAST = 5'h18;
    localparam logic [4:0] BT_TAG = 5'h02;
    localparam logic [4:0] BT_LINE_FIRST = 5'h03;
    localparam logic [4:0] BT_LINE_LAST = 5'h07;
    localparam logic [4:0] BT_NC_CARRY = 5'h07;
    localparam logic [4:0] BT_NC_FIRST = 5'h08;
    localparam logic [4:0] BT_NC_LAST = 5'h0f;
    localparam logic [4:0] BT_OP_FIRST = 5'h09;
    localparam logic [4:0] BT_OP_LAST = 5'h0e;
    localparam logic [4:0] BT_NO_CARRY = 5'h0f;
    localparam logic [4:0] BT_NO_FIRST = 5'h10;
    localparam logic [4:0] BT_NO_LAST = 5'h17;
    localparam logic [31:0] CTRL_OFFSET = 32'h0000_0000;
    localparam logic [31:0] STATUS_OFFSET = 32'h0000_0004;
    localparam logic [31:0] FETCH_OFFSET = 32'h0000_0008;
    localparam logic [3:0] CTRL_SEL_RESET = 4'h0;
    localparam logic [4:0] CTRL_INDEX_RESET = 5'h00;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [1:0] {PH_ONE, PH_TWO, PH_THREE, PH_FOUR} scfs_phase_t;
    typedef struct packed {
        logic [4:0] line;
        logic [5:0] opcode;
        logic [7:0] op_sector;
        logic [7:0] next_addr;
    } scfs_fetch_t;
endpackage

//--- scfs_top.sv
/*
 * serial command fetch sequencer: sector counter, fetch shift logic, phase
 * sequencing, parity handling and an axi4-lite register slave.
 * assumes memory lines are clocked one bit per aclk; panel switches are
 * asynchronous pins and get synchronised here.
 */
// Design decisions made here: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps
module scfs_top
    import scfs_pkg::*;
#(
    parameter int SYNC_STAGES = 2
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write address
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // axi4-lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // memory lines
    input wire logic counter_line_read_bit,
    output logic counter_line_write_bit,
    input wire logic [15:0] command_line_read,
    input wire logic [31:0] operand_line_read,
    output logic instruction_reg_write_bit,
    output logic fetch_gate,
    output logic [3:0] group_select,
    output logic [7:0] member_select,
    // execution side and panel
    input wire logic operand_parity_error,
    input wire logic enable_switch,
    input wire logic breakpoint_switch,
    output logic phase_bit_high,
    output logic phase_bit_low,
    output logic parity_error_flag
);
    // bit of an 8-bit field at the given pulse, lsb at the field's first pulse
    function automatic logic field_bit(input logic [7:0] v, input logic [4:0] bt, input logic [4:0] first);
        logic [4:0] idx;
        idx = bt - first;
        return v[idx[2:0]];
    endfunction

    function automatic logic in_window(input logic [4:0] bt, input logic [4:0] lo, input logic [4:0] hi);
        return (bt >= lo) && (bt <= hi);
    endfunction

    logic [4:0] bt_reg, bt_next;
    scfs_phase_t phase_reg, phase_next;
    logic carry_reg, carry_next;
    logic write_reg, write_next;
    logic iw_reg, iw_next;
    logic match_reg, match_next;
    logic parity_reg, parity_next;
    logic tag_reg, tag_next;
    scfs_fetch_t fetch_reg, fetch_next;
    logic [3:0] sel_reg, sel_next;
    logic [4:0] index_reg, index_next;
    logic [SYNC_STAGES-1:0] en_sync_reg, bp_sync_reg;
    logic vg;
    logic switches_clear;
    logic compare_bit, compare_on;

    // panel switch synchronisers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            en_sync_reg <= '0;
            bp_sync_reg <= '0;
        end else begin
            en_sync_reg <= {en_sync_reg[SYNC_STAGES-2:0], enable_switch};
            bp_sync_reg <= {bp_sync_reg[SYNC_STAGES-2:0], breakpoint_switch};
        end
    end
    assign switches_clear = en_sync_reg[SYNC_STAGES-1] && bp_sync_reg[SYNC_STAGES-1];

    assign vg = command_line_read[sel_reg];

    always_comb begin
        group_select = 4'h0;
        member_select = 8'h00;
        group_select[fetch_reg.line[4:3]] = 1'b1;
        member_select[fetch_reg.line[2:0]] = 1'b1;
    end
    assign fetch_gate = operand_line_read[fetch_reg.line];

    // sector compare source depends on phase
    always_comb begin
        compare_on = 1'b0;
        compare_bit = 1'b0;
        unique case (phase_reg)
            PH_ONE: begin
                compare_on = in_window(bt_reg, BT_NC_FIRST, BT_NC_LAST);
                compare_bit = field_bit(fetch_reg.next_addr, bt_reg, BT_NC_FIRST);
            end
            PH_TWO: begin
                compare_on = in_window(bt_reg, BT_NO_FIRST, BT_NO_LAST);
                compare_bit = vg;
            end
            PH_THREE: begin
                compare_on = in_window(bt_reg, BT_NO_FIRST, BT_NO_LAST);
                compare_bit = field_bit(fetch_reg.op_sector, bt_reg, BT_NO_FIRST);
            end
            PH_FOUR: begin
                compare_on = 1'b0;
                compare_bit = 1'b0;
            end
        endcase
    end

    // sector counter, runs whatever the phase
    always_comb begin
        bt_next = (bt_reg == BT_LAST) ? BT_FIRST : bt_reg + 5'h01;
        // no phase term in the counter
        carry_next = carry_reg;
        if (carry_reg && !counter_line_read_bit && in_window(bt_reg, BT_NC_FIRST, BT_NC_LAST - 5'h01)) begin
            carry_next = 1'b0;
        end
        // same for the operand sector field
        if (carry_reg && !counter_line_read_bit && in_window(bt_reg, BT_NO_FIRST, BT_NO_LAST - 5'h01)) begin
            carry_next = 1'b0;
        end
        if (bt_reg == BT_NC_CARRY) begin
            carry_next = 1'b1;
        end
        if (bt_reg == BT_NO_CARRY) begin
            carry_next = 1'b1;
        end
        if (bt_reg == BT_NO_LAST) begin
            carry_next = 1'b0;
        end
        write_next = counter_line_read_bit ^ carry_reg;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bt_reg <= BT_FIRST;
            carry_reg <= 1'b0;
            write_reg <= 1'b0;
        end else begin
            bt_reg <= bt_next;
            carry_reg <= carry_next;
            write_reg <= write_next;
        end
    end
    assign counter_line_write_bit = write_reg;

    // fetch shifting, match, parity and phase
    always_comb begin
        fetch_next = fetch_reg;
        tag_next = tag_reg;
        iw_next = 1'b0;
        match_next = match_reg;
        parity_next = parity_reg;
        phase_next = phase_reg;
        if (phase_reg == PH_TWO) begin
            if (bt_reg == BT_TAG) begin
                tag_next = vg;
            end
            // line shift gate, top stage downward
            if (in_window(bt_reg, BT_LINE_FIRST, BT_LINE_LAST)) begin
                fetch_next.line = {tag_reg ? index_reg[3'(bt_reg - BT_LINE_FIRST)] : vg, fetch_reg.line[4:1]};
            end
            if (in_window(bt_reg, BT_OP_FIRST, BT_OP_LAST)) begin
                fetch_next.opcode = {vg, fetch_reg.opcode[5:1]};
            end
            if (in_window(bt_reg, BT_NC_FIRST, BT_NC_LAST)) begin
                fetch_next.next_addr = {counter_line_read_bit, fetch_reg.next_addr[7:1]};
                iw_next = counter_line_read_bit;
            end
            if (in_window(bt_reg, BT_NO_FIRST, BT_NO_LAST)) begin
                fetch_next.op_sector = {vg, fetch_reg.op_sector[7:1]};
                iw_next = vg;
            end
        end
        if (compare_on && (compare_bit != counter_line_read_bit)) begin
            match_next = 1'b0;
        end
        if (bt_reg == BT_LAST) begin
            match_next = 1'b1;
        end
        // switches clear the flag, a new error wins
        if (switches_clear) begin
            parity_next = 1'b0;
        end
        if (phase_reg == PH_TWO && bt_reg != BT_FIRST && vg) begin
            parity_next = ~parity_reg;
        end
        if (operand_parity_error) begin
            parity_next = 1'b1;
        end
        unique case (phase_reg)
            PH_ONE: begin
                if (bt_reg == BT_LAST && match_reg) begin
                    phase_next = PH_TWO;
                end
            end
            PH_TWO: begin
                // one pulse of phase two while the flag stands
                if (bt_reg == BT_FIRST && parity_reg) begin
                    phase_next = PH_ONE;
                end else if (bt_reg == BT_LAST) begin
                    phase_next = match_reg ? PH_FOUR : PH_THREE;
                end
            end
            PH_THREE: begin
                if (bt_reg == BT_LAST && match_reg) begin
                    phase_next = PH_FOUR;
                end
            end
            PH_FOUR: begin
                phase_next = PH_ONE;
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fetch_reg <= '0;
            tag_reg <= 1'b0;
            iw_reg <= 1'b0;
            match_reg <= 1'b0;
            parity_reg <= 1'b0;
            phase_reg <= PH_ONE;
        end else begin
            fetch_reg <= fetch_next;
            tag_reg <= tag_next;
            iw_reg <= iw_next;
            match_reg <= match_next;
            parity_reg <= parity_next;
            phase_reg <= phase_next;
        end
    end
    assign instruction_reg_write_bit = iw_reg;
    assign parity_error_flag = parity_reg;
    assign phase_bit_high = (phase_reg == PH_THREE) || (phase_reg == PH_FOUR);
    assign phase_bit_low = (phase_reg == PH_TWO) || (phase_reg == PH_THREE);

    // axi4-lite slave
    logic aw_have_reg, aw_have_next, w_have_reg, w_have_next;
    logic [31:0] awaddr_reg, awaddr_next, wdata_reg, wdata_next;
    logic [3:0] wstrb_reg, wstrb_next;
    logic bvalid_reg, bvalid_next, rvalid_reg, rvalid_next;
    logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
    logic [31:0] rdata_reg, rdata_next;

    assign s_axi_awready = !aw_have_reg && !bvalid_reg;
    assign s_axi_wready = !w_have_reg && !bvalid_reg;
    assign s_axi_arready = !rvalid_reg;

    always_comb begin
        aw_have_next = aw_have_reg;
        w_have_next = w_have_reg;
        awaddr_next = awaddr_reg;
        wdata_next = wdata_reg;
        wstrb_next = wstrb_reg;
        bvalid_next = bvalid_reg;
        bresp_next = bresp_reg;
        rvalid_next = rvalid_reg;
        rresp_next = rresp_reg;
        rdata_next = rdata_reg;
        sel_next = sel_reg;
        index_next = index_reg;
        if (s_axi_awvalid && s_axi_awready) begin
            aw_have_next = 1'b1;
            awaddr_next = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_have_next = 1'b1;
            wdata_next = s_axi_wdata;
            wstrb_next = s_axi_wstrb;
        end
        if (aw_have_reg && w_have_reg) begin
            aw_have_next = 1'b0;
            w_have_next = 1'b0;
            bvalid_next = 1'b1;
            bresp_next = RESP_OKAY;
            if (awaddr_reg[31:2] == CTRL_OFFSET[31:2]) begin
                if (wstrb_reg[0]) begin
                    sel_next = wdata_reg[3:0];
                end
                if (wstrb_reg[1]) begin
                    index_next = wdata_reg[12:8];
                end
            end else if (awaddr_reg[31:2] != STATUS_OFFSET[31:2] && awaddr_reg[31:2] != FETCH_OFFSET[31:2]) begin
                bresp_next = RESP_SLVERR;
            end
        end
        if (bvalid_reg && s_axi_bready) begin
            bvalid_next = 1'b0;
        end
        if (rvalid_reg && s_axi_rready) begin
            rvalid_next = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            rvalid_next = 1'b1;
            rresp_next = RESP_OKAY;
            if (s_axi_araddr[31:2] == CTRL_OFFSET[31:2]) begin
                rdata_next = {19'h0, index_reg, 4'h0, sel_reg};
            end else if (s_axi_araddr[31:2] == STATUS_OFFSET[31:2]) begin
                rdata_next = {24'h0, carry_reg, match_reg, tag_reg, parity_reg, 2'h0, phase_bit_high, phase_bit_low};
            end else if (s_axi_araddr[31:2] == FETCH_OFFSET[31:2]) begin
                rdata_next = {3'h0, fetch_reg.line, 2'h0, fetch_reg.opcode, fetch_reg.op_sector, fetch_reg.next_addr};
            end else begin
                rdata_next = 32'h0000_0000;
                rresp_next = RESP_SLVERR;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_reg <= 1'b0;
            w_have_reg <= 1'b0;
            awaddr_reg <= 32'h0000_0000;
            wdata_reg <= 32'h0000_0000;
            wstrb_reg <= 4'h0;
            bvalid_reg <= 1'b0;
            bresp_reg <= RESP_OKAY;
            rvalid_reg <= 1'b0;
            rresp_reg <= RESP_OKAY;
            rdata_reg <= 32'h0000_0000;
            sel_reg <= CTRL_SEL_RESET;
            index_reg <= CTRL_INDEX_RESET;
        end else begin
            aw_have_reg <= aw_have_next;
            w_have_reg <= w_have_next;
            awaddr_reg <= awaddr_next;
            wdata_reg <= wdata_next;
            wstrb_reg <= wstrb_next;
            bvalid_reg <= bvalid_next;
            bresp_reg <= bresp_next;
            rvalid_reg <= rvalid_next;
            rresp_reg <= rresp_next;
            rdata_reg <= rdata_next;
            sel_reg <= sel_next;
            index_reg <= index_next;
        end
    end
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rresp = rresp_reg;
    assign s_axi_rdata = rdata_reg;

    // checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_phase3_hit;
        phase_reg == PH_THREE && bt_reg == BT_LAST && match_reg;
    endsequence
    sequence s_four_then_one;
        phase_reg == PH_FOUR ##1 phase_reg == PH_ONE;
    endsequence

    chk_carry_nc_set: assert property (bt_reg == BT_NC_CARRY |=> carry_reg)
        else $error("carry not set before next sector field");
    chk_carry_no_set: assert property (bt_reg == BT_NO_CARRY |=> carry_reg)
        else $error("carry not set before operand sector field");
    chk_carry_end: assert property (bt_reg == BT_NO_LAST |=> !carry_reg [*8])
        else $error("carry survives into buffer bits");
    chk_write_copy: assert property (!carry_reg |=> write_reg == $past(counter_line_read_bit))
        else $error("counter bit not recirculated");
    chk_write_compl: assert property (carry_reg |=> write_reg != $past(counter_line_read_bit))
        else $error("counter bit not complemented under carry");
    chk_carry_zero: assert property (carry_reg && !counter_line_read_bit && bt_reg >= BT_NC_FIRST
        && bt_reg < BT_NC_LAST |=> !carry_reg)
        else $error("carry kept after zero bit");
    chk_pulse_wrap: assert property (bt_reg == BT_LAST |=> bt_reg == BT_FIRST ##1 bt_reg == BT_TAG)
        else $error("pulse counter does not wrap");
    chk_tag_load: assert property (phase_reg == PH_TWO && bt_reg == BT_TAG |=> tag_reg == $past(vg))
        else $error("index tag not loaded");
    chk_two_exit: assert property (phase_reg == PH_TWO && bt_reg == BT_LAST
        |=> phase_reg == ($past(match_reg) ? PH_FOUR : PH_THREE))
        else $error("wrong phase after fetch");
    chk_four_one: assert property (phase_reg == PH_FOUR |=> phase_reg == PH_ONE)
        else $error("phase four longer than one pulse");
    chk_three_wait: assert property (s_phase3_hit |=> s_four_then_one)
        else $error("phase three exit wrong");
    chk_parity_loop: assert property (phase_reg == PH_TWO && bt_reg == BT_FIRST && parity_reg
        |=> phase_reg == PH_ONE)
        else $error("no return to phase one on parity");
    chk_line_hold: assert property (!(phase_reg == PH_TWO && bt_reg >= BT_LINE_FIRST
        && bt_reg <= BT_LINE_LAST) |=> $stable(fetch_reg.line))
        else $error("line bits moved outside gate");
    chk_one_wait: assert property (phase_reg == PH_ONE && !(bt_reg == BT_LAST && match_reg)
        |=> phase_reg == PH_ONE)
        else $error("phase one left without match");
endmodule

//--- testbench.sv
/*
 * self-checking bench of the fetch sequencer: axi4-lite tasks, counter
 * watch, fetch and parity checks. assumes scfs_mem_model as far side.
 */
`timescale 1ns/1ps
module testbench;
    import scfs_pkg::*;
    localparam logic [23:0] CMD = 24'h4ca144;
    // same fields, index tag set and even parity kept by pulse 24
    localparam logic [23:0] CMD2 = 24'hcca146;
    logic [23:0] cmd_word = CMD;
    logic in_two = 0;
    logic aclk = 0, aresetn = 0;
    logic [31:0] s_axi_awaddr = 0, s_axi_wdata = 0, s_axi_araddr = 0, s_axi_rdata, operand_line_read;
    logic [3:0] s_axi_wstrb = 4'hf, group_select, sel = 4'h0;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic counter_line_read_bit, counter_line_write_bit, instruction_reg_write_bit, fetch_gate;
    logic [15:0] command_line_read;
    logic [7:0] member_select, nc_prev, no_prev;
    logic operand_parity_error = 0, enable_switch = 0, breakpoint_switch = 0;
    logic phase_bit_high, phase_bit_low, parity_error_flag;
    logic [4:0] pc = 5'h01;
    logic [24:1] wb, ib;
    logic [31:0] d;
    int err_count = 0, samples_checked = 0, cyc = 0, words = 0;
    always #2.5 aclk = ~aclk;
    scfs_top scfs_top_inst(.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .counter_line_read_bit, .counter_line_write_bit, .command_line_read,
        .operand_line_read, .instruction_reg_write_bit, .fetch_gate, .group_select, .member_select,
        .operand_parity_error, .enable_switch, .breakpoint_switch, .phase_bit_high, .phase_bit_low,
        .parity_error_flag);
    scfs_mem_model scfs_mem_model_inst(.aclk(aclk), .aresetn(aresetn), .sel(sel), .word(cmd_word),
        .write_bit(counter_line_write_bit), .read_bit(counter_line_read_bit),
        .cmd(command_line_read), .opl(operand_line_read));
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task print_verdict();
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task wr(input logic [31:0] a, input logic [31:0] v, input logic [1:0] er);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        chk("bresp", 32'(s_axi_bresp), 32'(er));
    endtask
    task rd(input logic [31:0] a, output logic [31:0] v, output logic [1:0] rr);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        v = s_axi_rdata;
        rr = s_axi_rresp;
    endtask
    // counter word watch: write bits of the last word, pulse 1 upward
    always @(posedge aclk) begin
        cyc++;
        if (cyc > 20000) begin
            err_count++;
            print_verdict();
        end
        if (!aresetn) begin
            pc <= BT_FIRST;
        end else begin
            wb[(pc == BT_FIRST) ? 24 : int'(pc) - 1] = counter_line_write_bit;
            ib[(pc == BT_FIRST) ? 24 : int'(pc) - 1] = instruction_reg_write_bit;
            if (pc == 5'h02) begin
                in_two = phase_bit_low && !phase_bit_high;
            end
            if (pc == BT_FIRST) begin
                words++;
                if (words > 2) begin
                    chk("next sector", 32'(wb[15:8]), 32'(8'(nc_prev + 8'h01)));
                    chk("operand sector", 32'(wb[23:16]), 32'(8'(no_prev + 8'h01)));
                    chk("buffer bits", 32'({wb[24], wb[7:1]}), 32'h0);
                    if (in_two) begin
                        chk("iw next sector", 32'(ib[15:8]), 32'(nc_prev));
                        chk("iw op sector", 32'(ib[23:16]), 32'h99);
                    end else begin
                        chk("iw idle", 32'(ib), 32'h0);
                    end
                end
                nc_prev = wb[15:8];
                no_prev = wb[23:16];
            end
            pc <= (pc == BT_LAST) ? BT_FIRST : pc + 5'h01;
        end
    end
    initial begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        rd(CTRL_OFFSET, d, r);
        chk("ctrl reset", d, 32'h0);
        wr(CTRL_OFFSET, 32'h0000_1305, RESP_OKAY);
        sel <= 4'h5;
        rd(CTRL_OFFSET, d, r);
        chk("ctrl", d, 32'h0000_1305);
        wr(32'h0000_0040, 32'h1, RESP_SLVERR);
        rd(32'h0000_0040, d, r);
        chk("unmapped", {d[29:0], r}, {30'h0, RESP_SLVERR});
        wr(STATUS_OFFSET, 32'hffff_ffff, RESP_OKAY);
        $display("register test done");
        operand_parity_error <= 1'b1;
        @(posedge aclk);
        operand_parity_error <= 1'b0;
        repeat (3) @(posedge aclk);
        rd(STATUS_OFFSET, d, r);
        chk("parity set", 32'(d[4]), 32'h1);
        enable_switch <= 1'b1;
        breakpoint_switch <= 1'b1;
        repeat (6) @(posedge aclk);
        enable_switch <= 1'b0;
        breakpoint_switch <= 1'b0;
        repeat (3) @(posedge aclk);
        rd(STATUS_OFFSET, d, r);
        chk("parity cleared", 32'(d[4]), 32'h0);
        $display("parity test done");
        while (words < 262) @(posedge aclk);
        rd(FETCH_OFFSET, d, r);
        chk("opcode", 32'(d[21:16]), 32'h21);
        chk("op sector", 32'(d[15:8]), 32'h99);
        chk("line", 32'(d[28:24]), 32'h11);
        chk("group", 32'(group_select), 32'h4);
        chk("member", 32'(member_select), 32'h2);
        chk("fetch gate", 32'(fetch_gate), 32'(operand_line_read[17]));
        chk("next addr", 32'(d[7:0]), 32'h01);
        rd(STATUS_OFFSET, d, r);
        chk("no parity", 32'(d[4]), 32'h0);
        chk("phase three", 32'(d[1:0]), 32'h3);
        $display("fetch test done");
        while (words < 412) @(posedge aclk);
        rd(STATUS_OFFSET, d, r);
        chk("phase one", 32'(d[1:0]), 32'h0);
        $display("operand wait test done");
        cmd_word <= CMD2;
        while (words < 517) @(posedge aclk);
        rd(FETCH_OFFSET, d, r);
        chk("indexed line", 32'(d[28:24]), 32'h13);
        chk("next addr 2", 32'(d[7:0]), 32'h02);
        chk("member 2", 32'(member_select), 32'h08);
        rd(STATUS_OFFSET, d, r);
        chk("tag set", 32'(d[5]), 32'h1);
        $display("indexed fetch test done");
        print_verdict();
    end
endmodule
